// ---- include/failsafe_pkg.sv ----
// Constants, types and register map of the drive status output block
// Function
// - A fault trip drives the fault indication active.
// - Negative-logic fault output is on while healthy, off after a fault.
// - Ready indication is on once powered and operative.
// - Running indication holds through deceleration until motor output stops.
// - Current detected when operating above a level, default 150 percent.
// - Codes 99/199 select fault, 11/111 select ready, positive/negative logic.
// - Codes 0/100 select running, 12/112 select current detected.
// - By default fault drives the relay terminal, running the running terminal.
package failsafe_pkg;
    localparam int CUR_W = 16;
    localparam int CODE_W = 8;
    localparam int NTERM = 8;
    localparam int NPIN = 4;
    localparam int IND_W = 4;
    // Pin positions in the synchronised input vector
    localparam int PIN_FAULT = 0;
    localparam int PIN_POWER = 1;
    localparam int PIN_RUN = 2;
    localparam int PIN_OUT = 3;
    // Word indices; byte offset is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_STAT = 4'h1;
    localparam logic [3:0] IDX_LEVEL = 4'h2;
    localparam logic [3:0] IDX_ISTAT = 4'h3;
    localparam logic [3:0] IDX_IMASK = 4'h4;
    localparam logic [3:0] IDX_TERM0 = 4'h5;
    localparam logic [3:0] IDX_TERM_LAST = 4'hc;
    localparam int CTRL_CLR_BIT = 0;
    // Level in units of 0.1 percent of rated current
    localparam logic [CUR_W-1:0] LEVEL_RST = 16'h05dc;
    localparam logic [CUR_W-1:0] LEVEL_INTERLOCK = 16'h00c8;
    // Output terminal function codes
    localparam logic [CODE_W-1:0] FC_FAULT_POS = 8'h63;
    localparam logic [CODE_W-1:0] FC_FAULT_NEG = 8'hc7;
    localparam logic [CODE_W-1:0] FC_READY_POS = 8'h0b;
    localparam logic [CODE_W-1:0] FC_READY_NEG = 8'h6f;
    localparam logic [CODE_W-1:0] FC_RUN_POS = 8'h00;
    localparam logic [CODE_W-1:0] FC_RUN_NEG = 8'h64;
    localparam logic [CODE_W-1:0] FC_CUR_POS = 8'h0c;
    localparam logic [CODE_W-1:0] FC_CUR_NEG = 8'h70;
    localparam logic [CODE_W-1:0] FC_NONE = 8'hff;
    // Slot 0 is the fault relay terminal, slot 1 the running terminal
    localparam logic [NTERM-1:0][CODE_W-1:0] TERM_RST = {
        FC_NONE, FC_NONE, FC_NONE, FC_NONE,
        FC_NONE, FC_NONE, FC_RUN_POS, FC_FAULT_POS};
    // Indications; interrupt status and mask share this layout
    typedef struct packed {
        logic curdet;
        logic running;
        logic ready;
        logic fault;
    } ind_t;
    localparam ind_t IND_RST = 4'h0;
endpackage

// ---- design/drive_failsafe_interlock.sv ----
// Drive status indications, terminal function mapping and register slave
`timescale 1ns/10ps
module drive_failsafe_interlock
    import failsafe_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // Drive pins from the power stage
    input wire logic FAULT_DETECT,
    input wire logic POWER_OK,
    input wire logic INV_RUN,
    input wire logic OUT_ACTIVE,
    // Current sample on the system clock
    input wire logic [CUR_W-1:0] MOTOR_CURRENT,
    // Avalon-MM slave
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Output terminals
    output logic FAULT_RELAY,
    output logic RUN_TERM,
    output logic [NTERM-3:0] OUT_TERM,
    // Interrupt
    output logic IRQ
);

    // Maps one function code onto the indications
    function automatic logic term_map(
        input logic [CODE_W-1:0] code,
        input ind_t ind);
        logic v;
        v = 1'b0;
        case (code)
            FC_FAULT_POS: v = ind.fault;
            FC_FAULT_NEG: v = ~ind.fault;
            FC_READY_POS: v = ind.ready;
            FC_READY_NEG: v = ~ind.ready;
            FC_RUN_POS: v = ind.running;
            FC_RUN_NEG: v = ~ind.running;
            FC_CUR_POS: v = ind.curdet;
            FC_CUR_NEG: v = ~ind.curdet;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // Synchroniser and filter state
    logic [NPIN-1:0] s1_r, s2_r, s3_r, flt_r;
    logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;
    // Indication and terminal state
    ind_t ind_r, ind_nxt;
    logic [NTERM-1:0] term_r, term_nxt;
    // Interrupt state
    ind_t istat_r, istat_nxt, imask_r, imask_nxt;
    logic irq_r, irq_nxt;
    // Register and bus state
    logic [CUR_W-1:0] level_r, level_nxt;
    logic [NTERM-1:0][CODE_W-1:0] code_r, code_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Decode helpers
    logic [3:0] idx;
    logic wr_go;
    logic [31:0] wmask, wdm;
    logic fault_clr;
    ind_t events;

    // Change counts only once the second and third stages agree
    always_comb begin
        s1_nxt = {OUT_ACTIVE, INV_RUN, POWER_OK, FAULT_DETECT};
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        flt_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & flt_r);
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            flt_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            flt_r <= flt_nxt;
        end
    end

    // Bus decode; a write lands at the edge that sees waitrequest low
    assign idx = AVS_ADDRESS[5:2];
    assign wr_go = AVS_WRITE & ~wait_r;
    assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign wdm = AVS_WRITEDATA & wmask;
    assign fault_clr = wr_go && (idx == IDX_CTRL) && wdm[CTRL_CLR_BIT];

    // Indications; the fault latch keeps a trip until software clears it
    always_comb begin
        ind_nxt.fault = flt_r[PIN_FAULT] | (ind_r.fault & ~fault_clr);
        ind_nxt.ready = flt_r[PIN_POWER] & ~ind_r.fault;
        // Output still active means the motor is decelerating, so hold
        ind_nxt.running = flt_r[PIN_RUN] | flt_r[PIN_OUT];
        ind_nxt.curdet = flt_r[PIN_OUT] & (MOTOR_CURRENT > level_r);
        for (int i = 0; i < NTERM; i++) begin
            term_nxt[i] = term_map(code_r[i], ind_r);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ind_r <= IND_RST;
            term_r <= '0;
        end else begin
            ind_r <= ind_nxt;
            term_r <= term_nxt;
        end
    end

    // Terminals come straight from their flops
    assign FAULT_RELAY = term_r[0];
    assign RUN_TERM = term_r[1];
    assign OUT_TERM = term_r[NTERM-1:2];

    // Rising indications set sticky bits; a set beats a same-cycle clear
    always_comb begin
        events = ind_nxt & ~ind_r;
        istat_nxt = istat_r;
        imask_nxt = imask_r;
        if (wr_go && (idx == IDX_ISTAT)) begin
            istat_nxt = istat_r & ~wdm[IND_W-1:0];
        end
        istat_nxt = istat_nxt | events;
        if (wr_go && (idx == IDX_IMASK)) begin
            imask_nxt = (imask_r & ~wmask[IND_W-1:0]) | wdm[IND_W-1:0];
        end
        irq_nxt = |(istat_r & imask_r);
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            istat_r <= IND_RST;
            imask_r <= IND_RST;
            irq_r <= 1'b0;
        end else begin
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign IRQ = irq_r;

    // Register writes, read mux and the one-wait-state handshake
    always_comb begin
        level_nxt = level_r;
        code_nxt = code_r;
        rdata_nxt = rdata_r;
        // Drop wait for one cycle per request, then rearm
        wait_nxt = ~((AVS_READ | AVS_WRITE) & wait_r);
        if (wr_go && (idx == IDX_LEVEL)) begin
            level_nxt = (level_r & ~wmask[CUR_W-1:0]) | wdm[CUR_W-1:0];
        end
        for (int i = 0; i < NTERM; i++) begin
            if (wr_go && (idx == IDX_TERM0 + 4'(i))) begin
                code_nxt[i] = (code_r[i] & ~wmask[CODE_W-1:0]) | wdm[CODE_W-1:0];
            end
        end
        // Read data is captured a cycle early so it stands at the taking edge
        if (AVS_READ && wait_r) begin
            rdata_nxt = '0;
            case (idx)
                IDX_CTRL: rdata_nxt = '0; // Clear bit is self-clearing
                IDX_STAT: rdata_nxt[2*IND_W-1:0] = {flt_r, ind_r};
                IDX_LEVEL: rdata_nxt[CUR_W-1:0] = level_r;
                IDX_ISTAT: rdata_nxt[IND_W-1:0] = istat_r;
                IDX_IMASK: rdata_nxt[IND_W-1:0] = imask_r;
                default: begin
                    if (idx >= IDX_TERM0 && idx <= IDX_TERM_LAST) begin
                        rdata_nxt[CODE_W-1:0] = code_r[3'(idx - IDX_TERM0)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            level_r <= LEVEL_RST;
            code_r <= TERM_RST;
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            level_r <= level_nxt;
            code_r <= code_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign AVS_WAITREQUEST = wait_r;
    assign AVS_READDATA = rdata_r;

    // First cycle after reset, for checking the default assignment
    logic first_r;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            first_r <= 1'b0;
        end else begin
            first_r <= 1'b1;
        end
    end

    // A filtered trip shows as fault and kills ready after it
    property p_fault_trip;
        @(posedge CLK_SYS) disable iff (!RST_B)
        $rose(flt_r[PIN_FAULT]) |=> ind_r.fault ##1 !ind_r.ready;
    endproperty
    a_fault_trip: assert property (p_fault_trip)
        else $error("fault trip not indicated");

    // Negative logic relay is low the cycle after a fault shows
    property p_fault_neg;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (code_r[0] == FC_FAULT_NEG) && ind_r.fault |=> !FAULT_RELAY;
    endproperty
    a_fault_neg: assert property (p_fault_neg)
        else $error("negative logic fault relay wrong");

    // Powered and healthy leads to ready
    property p_ready;
        @(posedge CLK_SYS) disable iff (!RST_B)
        flt_r[PIN_POWER] && !ind_r.fault && !flt_r[PIN_FAULT] [*2] |-> ind_r.ready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready not shown when powered");

    // Running holds while output stays active after the run pin drops
    property p_running_hold;
        @(posedge CLK_SYS) disable iff (!RST_B)
        $fell(flt_r[PIN_RUN]) && flt_r[PIN_OUT] |=> ind_r.running;
    endproperty
    a_running_hold: assert property (p_running_hold)
        else $error("running dropped during deceleration");

    // Current detection needs active output and current above level
    property p_curdet;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ind_r.curdet |-> $past(flt_r[PIN_OUT]) && ($past(MOTOR_CURRENT) > $past(level_r));
    endproperty
    a_curdet: assert property (p_curdet)
        else $error("current detected without cause");

    // Ready positive code follows the ready indication
    property p_ready_map;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (code_r[2] == FC_READY_POS) |=> (OUT_TERM[0] == $past(ind_r.ready));
    endproperty
    a_ready_map: assert property (p_ready_map)
        else $error("ready code mapping wrong");

    // Negative current code inverts the current indication
    property p_cur_neg_map;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (code_r[3] == FC_CUR_NEG) |=> (OUT_TERM[1] != $past(ind_r.curdet));
    endproperty
    a_cur_neg_map: assert property (p_cur_neg_map)
        else $error("current negative code mapping wrong");

    // Defaults put fault on the relay and running on its terminal
    property p_defaults;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !first_r |-> (code_r[0] == FC_FAULT_POS) && (code_r[1] == FC_RUN_POS)
            && (level_r == LEVEL_RST);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("default terminal assignment wrong");

    // A latched trip stays shown until software clears it
    property p_fault_hold;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ind_r.fault && !fault_clr |=> ind_r.fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault latch lost before clear");

    // Running drops once both run and output pins have gone quiet
    property p_running_drop;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !flt_r[PIN_RUN] && !flt_r[PIN_OUT] |=> !ind_r.running;
    endproperty
    a_running_drop: assert property (p_running_drop)
        else $error("running held after output stopped");

    // Current above the level with output on must be flagged
    property p_curdet_set;
        @(posedge CLK_SYS) disable iff (!RST_B)
        flt_r[PIN_OUT] && (MOTOR_CURRENT > level_r) |=> ind_r.curdet;
    endproperty
    a_curdet_set: assert property (p_curdet_set)
        else $error("current above level not detected");

    // Positive fault code drives the relay from the fault indication
    property p_relay_pos;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (code_r[0] == FC_FAULT_POS) |=> (FAULT_RELAY == $past(ind_r.fault));
    endproperty
    a_relay_pos: assert property (p_relay_pos)
        else $error("fault relay does not follow fault");

endmodule

// ---- verif/motor_stage_model.sv ----
// Power stage model that feeds the drive status pins of the interlock block
`timescale 1ns/10ps
module motor_stage_model #(
    parameter int DECEL = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Commands from the bench
    input wire logic start,
    input wire logic trip,
    input wire logic power,
    input wire logic [15:0] cur_in,
    // Drive pins
    output logic fault_pin,
    output logic power_pin,
    output logic run_pin,
    output logic out_pin,
    output logic [15:0] cur_pin,
    // Sequence controller side
    input wire logic run_ind,
    input wire logic alarm_clr,
    output logic alarm
);
    int cnt;
    logic run_c;
    logic on_c;
    // A trip cuts the output at once; a plain stop coasts down for DECEL-1 cycles
    assign run_c = start && power && !trip;
    assign on_c = run_c || (cnt > 1 && !trip);
    // Pins change only just after a rising edge, like a registered stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            fault_pin <= 1'b0;
            power_pin <= 1'b0;
            run_pin <= 1'b0;
            out_pin <= 1'b0;
            cur_pin <= 16'h0000;
        end else begin
            cnt <= run_c ? DECEL : ((cnt > 0 && !trip) ? cnt - 1 : 0);
            fault_pin <= trip;
            power_pin <= power;
            run_pin <= run_c;
            out_pin <= on_c;
            cur_pin <= on_c ? cur_in : 16'h0000;
        end
    end

    // Sequence controller; each cross-check gets WIN cycles, which covers the coast-down
    localparam int WIN = DECEL + 16;
    int gap_cnt;
    logic gap_c;
    // The coast counter stands in for the measured shaft speed
    assign gap_c = (start != run_ind)
        || (start != (cur_pin != 16'h0000))
        || ((start ? DECEL : 0) != cnt);
    // Alarm latches until cleared; a failing check beats a same-cycle clear
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt <= 0;
            alarm <= 1'b0;
        end else begin
            gap_cnt <= gap_c ? gap_cnt + 1 : 0;
            alarm <= (gap_cnt >= WIN) || (alarm && !alarm_clr);
        end
    end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the drive status interlock block
`timescale 1ns/10ps
module tb;
    import failsafe_pkg::*;
    localparam int DECEL = 40;
    localparam logic [7:0] CODES [9] = '{FC_FAULT_POS, FC_FAULT_NEG, FC_READY_POS, FC_READY_NEG,
        FC_RUN_POS, FC_RUN_NEG, FC_CUR_POS, FC_CUR_NEG, 8'h05};
    localparam logic [5:0] RA [7] = '{6'h08, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h0c, 6'h34};
    localparam logic [31:0] RV [7] = '{32'h05dc, 32'h0, 32'h63, 32'h0, 32'hff, 32'h0, 32'h0};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0, trip = 1'b0, power = 1'b0;
    logic [15:0] cur = 16'h0000;
    logic fault_p, power_p, run_p, out_p;
    logic [15:0] cur_p;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, fault_relay, run_term, irq;
    logic [5:0] out_term;
    logic alarm_clr = 1'b0, alarm;
    // Reference state kept by the bench
    int start_i = 0, trip_i = 0, pwr_i = 0, lvl_i = 16'h05dc, latch_i = 0, outa_i = 0, cur_i = 0;
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    // Clock
    initial begin
        forever #2.5 clk_sys = !clk_sys;
    end
    motor_stage_model #(.DECEL(DECEL)) motor_stage_model_i (.clk(clk_sys), .rst_b(rst_b), .start(start),
        .trip(trip), .power(power), .cur_in(cur), .fault_pin(fault_p), .power_pin(power_p),
        .run_pin(run_p), .out_pin(out_p), .cur_pin(cur_p), .run_ind(run_term), .alarm_clr(alarm_clr),
        .alarm(alarm));
    drive_failsafe_interlock drive_failsafe_interlock_i (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .FAULT_DETECT(fault_p), .POWER_OK(power_p), .INV_RUN(run_p), .OUT_ACTIVE(out_p),
        .MOTOR_CURRENT(cur_p), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .FAULT_RELAY(fault_relay), .RUN_TERM(run_term),
        .OUT_TERM(out_term), .IRQ(irq));

    // Expected indications {curdet, running, ready, fault}
    function automatic logic [3:0] ind_e();
        int f, irun, c;
        irun = start_i & pwr_i & (trip_i == 0);
        f = trip_i | latch_i;
        c = (outa_i != 0) && (cur_i > lvl_i);
        return {1'(c), 1'(irun | outa_i), 1'(pwr_i != 0 && f == 0), 1'(f)};
    endfunction
    function automatic logic [31:0] stat_e();
        return {24'h0, 1'(outa_i), 1'(start_i & pwr_i & (trip_i == 0)), 1'(pwr_i), 1'(trip_i), ind_e()};
    endfunction
    // Terminal level that a function code selects
    function automatic logic map(input logic [7:0] code, input logic [3:0] ind);
        case (code)
            FC_FAULT_POS: return ind[0];
            FC_FAULT_NEG: return !ind[0];
            FC_READY_POS: return ind[1];
            FC_READY_NEG: return !ind[1];
            FC_RUN_POS: return ind[2];
            FC_RUN_NEG: return !ind[2];
            FC_CUR_POS: return ind[3];
            FC_CUR_NEG: return !ind[3];
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(nm, e, q);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard; the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h03f1));
        wait_n(4);
        rst_b <= 1'b1;
        wait_n(1);
        wr(6'h34, $urandom());
        for (int i = 0; i < 7; i++) rd(RA[i], RV[i], "reset_reg");
        wr(6'h08, 32'h12345678, 4'h1);
        lvl_i = 16'h0578;
        rd(6'h08, 32'h0578, "level_lane");
        power <= 1'b1;
        pwr_i = 1;
        wait_n(12);
        rd(6'h04, stat_e(), "stat_ready");
        wr(6'h08, 32'(LEVEL_INTERLOCK));
        lvl_i = LEVEL_INTERLOCK;
        cur_i = LEVEL_INTERLOCK + 1 + ($urandom() % 1000);
        cur <= 16'(cur_i);
        start <= 1'b1;
        start_i = 1;
        outa_i = 1;
        wait_n(12);
        rd(6'h04, stat_e(), "stat_run");
        chk("run_term", 32'(map(FC_RUN_POS, ind_e())), 32'(run_term));
        rd(6'h0c, 32'h0e, "istat_rise");
        for (int i = 0; i < 9; i++) begin
            wr(6'h1c, 32'(CODES[i]));
            wait_n(3);
            chk("out_term", 32'(map(CODES[i], ind_e())), 32'(out_term[0]));
        end
        wr(6'h20, 32'(FC_CUR_NEG));
        wait_n(3);
        chk("cur_neg_on", 32'(map(FC_CUR_NEG, ind_e())), 32'(out_term[1]));
        start <= 1'b0;
        start_i = 0;
        wait_n(12);
        chk("run_decel", 32'h1, 32'(run_term));
        rd(6'h04, stat_e(), "stat_decel");
        wait_n(DECEL + 12);
        outa_i = 0;
        chk("run_stop", 32'h0, 32'(run_term));
        cur_i = LEVEL_INTERLOCK;
        cur <= 16'(cur_i);
        start <= 1'b1;
        start_i = 1;
        outa_i = 1;
        wait_n(12);
        rd(6'h04, stat_e(), "stat_level_edge");
        chk("cur_neg_off", 32'(map(FC_CUR_NEG, ind_e())), 32'(out_term[1]));
        chk("alarm_idle", 32'h0, 32'(alarm));
        wr(6'h18, 32'(FC_NONE));
        wait_n(DECEL + 30);
        chk("alarm_set", 32'h1, 32'(alarm));
        wr(6'h18, 32'(FC_RUN_POS));
        wait_n(4);
        chk("alarm_latch", 32'h1, 32'(alarm));
        alarm_clr <= 1'b1;
        wait_n(1);
        alarm_clr <= 1'b0;
        wait_n(2);
        chk("alarm_clear", 32'h0, 32'(alarm));
        start <= 1'b0;
        start_i = 0;
        wait_n(DECEL + 20);
        outa_i = 0;
        wr(6'h0c, 32'hf);
        rd(6'h0c, 32'h0, "istat_clr");
        wr(6'h10, 32'h1);
        trip <= 1'b1;
        trip_i = 1;
        latch_i = 1;
        wait_n(12);
        chk("relay_trip", 32'h1, 32'(fault_relay));
        chk("irq_on", 32'h1, 32'(irq));
        rd(6'h04, stat_e(), "stat_trip");
        wr(6'h10, 32'h0);
        wait_n(3);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(6'h10, 32'h1);
        wait_n(3);
        chk("irq_unmask", 32'h1, 32'(irq));
        wr(6'h0c, 32'h1);
        wait_n(3);
        chk("irq_w1c", 32'h0, 32'(irq));
        trip <= 1'b0;
        trip_i = 0;
        wait_n(12);
        rd(6'h04, stat_e(), "stat_latch");
        wr(6'h14, 32'(FC_FAULT_NEG));
        wait_n(3);
        chk("relay_neg", 32'(map(FC_FAULT_NEG, ind_e())), 32'(fault_relay));
        wr(6'h00, 32'h1);
        latch_i = 0;
        wait_n(12);
        chk("relay_healthy", 32'h1, 32'(fault_relay));
        rd(6'h04, stat_e(), "stat_clear");
        chk("alarm_quiet", 32'h0, 32'(alarm));
        end_sim();
    end
endmodule
